//--- verilog/pfw_pkg.sv
// Package of offsets, field layouts, reset values and carriers for the prefetch window registers.
package pfw_pkg;

    // ------------------------------------------------------------------
    // Configuration dword offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] BOUNDS_OFF = 8'h24;
    localparam logic [7:0] RSVD_FIRST_OFF = 8'h28;
    localparam logic [7:0] RSVD_LAST_OFF = 8'h38;
    localparam logic [7:0] BRCTL_OFF = 8'h3C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int LIMIT_MSB = 31;
    localparam int LIMIT_LSB = 20;
    localparam int BASE_MSB = 15;
    localparam int BASE_LSB = 4;
    localparam int BRCTL_LSB = 16;
    localparam int BRCTL_MSB = 23;
    localparam int GRAN_BITS = 20;

    // ------------------------------------------------------------------
    // Write masks and reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] BOUNDS_WMASK = 32'hFFF0_FFF0;
    localparam logic [31:0] BOUNDS_RST = 32'h0000_0000;
    localparam logic [7:0] BRCTL_WMASK = 8'h6F;
    localparam logic [7:0] BRCTL_RST = 8'h00;
    localparam logic [19:0] GRAN_ONES = 20'hFFFFF;
    localparam logic [19:0] GRAN_ZEROS = 20'h00000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_s;

    typedef struct packed {
        logic valid;
        logic read;
        logic [31:0] addr;
    } mem_req_s;

    typedef logic [11:0] win_field_t;

endpackage : pfw_pkg

//--- verilog/prefetch_window_config_regs.sv
// Prefetchable window base/limit register, reserved span and bridge control dword.
`timescale 1ns/1ps


module prefetch_window_config_regs
    import pfw_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter bit PREFETCH_EN = 1'b1
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire cfg_req_s cfg_req_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_ack_out,
    input wire mem_req_s mem_req_in,
    output logic decode_valid_out,
    output logic fwd_out,
    output logic prefetch_out,
    output logic [7:0] bridge_ctrl_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // The decoder compares full 32-bit memory addresses only.
    generate
        if (ADDR_W != 32)
        begin : g_bad_addr_w
            $error("prefetch_window_config_regs supports ADDR_W of 32 only.");
        end
        // The bound fields and the granule fill must tile the address exactly.
        if ((LIMIT_MSB - LIMIT_LSB + 1) != $bits(win_field_t))
        begin : g_bad_limit_field
            $error("Upper-bound field width does not match the window field type.");
        end
        if ((BASE_MSB - BASE_LSB + 1) != $bits(win_field_t))
        begin : g_bad_base_field
            $error("Lower-bound field width does not match the window field type.");
        end
        if (($bits(win_field_t) + GRAN_BITS) != ADDR_W)
        begin : g_bad_granule
            $error("Window field and granule bits do not add up to the address width.");
        end
        if (LIMIT_LSB != GRAN_BITS)
        begin : g_bad_limit_pos
            $error("Upper-bound field must start at the granule boundary.");
        end
        if ((BRCTL_MSB - BRCTL_LSB + 1) != 8)
        begin : g_bad_brctl_field
            $error("Bridge control field must be one byte wide.");
        end
        if (RSVD_FIRST_OFF > RSVD_LAST_OFF)
        begin : g_bad_rsvd_span
            $error("Reserved span ends before it starts.");
        end
        if ((BOUNDS_RST & ~BOUNDS_WMASK) != 32'h0000_0000)
        begin : g_bad_bounds_rst
            $error("Bounds reset value sets bits that read as zero.");
        end
        if ((BRCTL_RST & ~BRCTL_WMASK) != 8'h00)
        begin : g_bad_brctl_rst
            $error("Bridge control reset value sets bits that read as zero.");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] byte_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                m[i*8 +: 8] = 8'hFF;
            end
        end
        return m;
    endfunction : byte_mask

    function automatic logic [31:0] merge_write(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [31:0] mask
    );
        return (old_val & ~mask) | (new_val & mask);
    endfunction : merge_write

    // The two low address bits never take part in selecting a dword.
    function automatic logic [5:0] dword_index(input logic [7:0] byte_addr);
        return byte_addr[7:2];
    endfunction : dword_index

    // A bound is a 12-bit field stretched over one 1 MB granule by a fill.
    function automatic logic [31:0] window_edge(
        input win_field_t field,
        input logic [19:0] fill
    );
        return {field, fill};
    endfunction : window_edge

    function automatic logic in_range(
        input logic [31:0] addr,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        return (addr >= lo) && (addr <= hi);
    endfunction : in_range

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    logic [5:0] req_dword;
    logic hit_bounds;
    logic hit_brctl;
    logic hit_rsvd;

    // Whole dwords are decoded; a hit with no byte enables still answers.
    always_comb
    begin
        req_dword = dword_index(cfg_req_in.addr);
        hit_bounds = (req_dword == dword_index(BOUNDS_OFF));
        hit_brctl = (req_dword == dword_index(BRCTL_OFF));
        hit_rsvd = (req_dword >= dword_index(RSVD_FIRST_OFF))
            && (req_dword <= dword_index(RSVD_LAST_OFF));
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] bounds_r;
    logic [31:0] bounds_nxt;
    logic [7:0] brctl_r;
    logic [7:0] brctl_nxt;

    logic [31:0] wmask;
    logic [31:0] brctl_word;
    logic [31:0] brctl_merged;

    // Bridge control stores only its byte; the rest of that dword is rebuilt
    // on every read, so read-only bits cannot drift.
    always_comb
    begin
        wmask = byte_mask(cfg_req_in.be);
        brctl_word = {8'h00, brctl_r, 16'h0000};
        brctl_merged = merge_write(brctl_word, cfg_req_in.wdata,
            wmask & {8'h00, BRCTL_WMASK, 16'h0000});
        bounds_nxt = bounds_r;
        brctl_nxt = brctl_r;
        if (cfg_req_in.wr && hit_bounds)
        begin
            // Only bits 31:20 and 15:4 take write data; the rest stay zero.
            bounds_nxt = merge_write(bounds_r, cfg_req_in.wdata,
                wmask & BOUNDS_WMASK);
        end
        if (cfg_req_in.wr && hit_brctl)
        begin
            brctl_nxt = brctl_merged[BRCTL_MSB:BRCTL_LSB];
        end
        // Writes into the reserved span fall through with no effect.
        if (cfg_req_in.wr && hit_rsvd)
        begin
            bounds_nxt = bounds_r;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            bounds_r <= BOUNDS_RST;
            brctl_r <= BRCTL_RST;
        end
        else
        begin
            bounds_r <= bounds_nxt;
            brctl_r <= brctl_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Configuration read port
    // ------------------------------------------------------------------
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic ack_r;
    logic ack_nxt;

    always_comb
    begin
        rdata_nxt = rdata_r;
        // Every access is acknowledged, refused ones too, so software never stalls.
        ack_nxt = cfg_req_in.wr | cfg_req_in.rd;
        // Reads see the registers before a same-cycle write lands, so a combined
        // read and write returns the old contents.
        if (cfg_req_in.rd)
        begin
            if (hit_bounds)
            begin
                rdata_nxt = bounds_r & BOUNDS_WMASK;
            end
            else if (hit_brctl)
            begin
                // Bit 20 and bit 23 are never written, so they keep their reset zero.
                rdata_nxt = brctl_word;
            end
            else if (hit_rsvd)
            begin
                rdata_nxt = READ_ZERO;
            end
            else
            begin
                // Dwords outside this block answer zero.
                rdata_nxt = READ_ZERO;
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            rdata_r <= READ_ZERO;
            ack_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------------
    win_field_t base_f;
    win_field_t limit_f;
    logic [31:0] win_lo;
    logic [31:0] win_hi;
    logic in_win;
    logic dec_vld_r;
    logic dec_vld_nxt;
    logic fwd_r;
    logic fwd_nxt;
    logic pf_r;
    logic pf_nxt;

    always_comb
    begin
        base_f = bounds_r[BASE_MSB:BASE_LSB];
        limit_f = bounds_r[LIMIT_MSB:LIMIT_LSB];
        win_lo = window_edge(base_f, GRAN_ZEROS);
        win_hi = window_edge(limit_f, GRAN_ONES);
        // With 1 MB granules the smallest non-empty window is one granule,
        // and a base above the limit leaves no address satisfying both.
        // The registered bounds are decoded, so a new window applies from the
        // cycle after its write; traffic in the write's own cycle sees the old one.
        in_win = in_range(mem_req_in.addr, win_lo, win_hi);
        dec_vld_nxt = mem_req_in.valid;
        fwd_nxt = mem_req_in.valid && in_win;
        pf_nxt = PREFETCH_EN && mem_req_in.valid && mem_req_in.read
            && in_win;
    end

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            dec_vld_r <= 1'b0;
            fwd_r <= 1'b0;
            pf_r <= 1'b0;
        end
        else
        begin
            dec_vld_r <= dec_vld_nxt;
            fwd_r <= fwd_nxt;
            pf_r <= pf_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Outputs come straight from flops, so the bridge sees no decode glitches.
    assign cfg_rdata_out = rdata_r;
    assign cfg_ack_out = ack_r;
    assign decode_valid_out = dec_vld_r;
    assign fwd_out = fwd_r;
    assign prefetch_out = pf_r;
    assign bridge_ctrl_out = brctl_r;

endmodule : prefetch_window_config_regs

//--- verification/pfw_chk_sva.sv
// Port checker for the prefetch window register block.
`timescale 1ns/1ps
module pfw_chk
    import pfw_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire cfg_req_s cfg_req_in,
    input wire logic [31:0] cfg_rdata_out,
    input wire logic cfg_ack_out,
    input wire mem_req_s mem_req_in,
    input wire logic decode_valid_out,
    input wire logic fwd_out,
    input wire logic prefetch_out,
    input wire logic [7:0] bridge_ctrl_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence bnd_rd;
        cfg_req_in.rd && cfg_req_in.addr[7:2] == BOUNDS_OFF[7:2];
    endsequence
    sequence rsvd_rd;
        cfg_req_in.rd && cfg_req_in.addr[7:2] >= RSVD_FIRST_OFF[7:2]
            && cfg_req_in.addr[7:2] <= RSVD_LAST_OFF[7:2];
    endsequence
    ack_follows_a: assert property ((cfg_req_in.wr || cfg_req_in.rd) |=> cfg_ack_out)
        else $error("ack missing after request");
    ack_cause_a: assert property (cfg_ack_out |-> $past(cfg_req_in.wr || cfg_req_in.rd))
        else $error("ack without request");
    bnd_zero_a: assert property (bnd_rd |=> cfg_rdata_out[19:16] == 4'h0
        && cfg_rdata_out[3:0] == 4'h0)
        else $error("bounds read-only bits not zero");
    rsvd_zero_a: assert property (rsvd_rd |=> cfg_rdata_out == READ_ZERO)
        else $error("reserved dword not zero");
    dec_delay_a: assert property (1'b1 |=> decode_valid_out == $past(mem_req_in.valid))
        else $error("decode valid timing wrong");
    fwd_valid_a: assert property (fwd_out |-> decode_valid_out)
        else $error("forward without request");
    pf_read_a: assert property (prefetch_out |-> fwd_out && $past(mem_req_in.read))
        else $error("prefetch outside window or on write");
    brctl_ro_a: assert property ((bridge_ctrl_out & ~BRCTL_WMASK) == 8'h00)
        else $error("bridge control read-only bit set");
    rst_clear_a: assert property ($fell(rst_in) |-> !fwd_out && cfg_rdata_out == 32'h0)
        else $error("outputs not clear after reset");
endmodule : pfw_chk

//--- verification/prefetch_window_config_regs_tb.sv
// Self-checking bench for the prefetch window register block.
`timescale 1ns/1ps
module prefetch_window_config_regs_tb;
    import pfw_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    cfg_req_s cfg_req = '0;
    mem_req_s mem_req = '0;
    logic [31:0] rdata;
    logic ack, dv, fwd, pf;
    logic [7:0] brctl;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    prefetch_window_config_regs i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .cfg_req_in(cfg_req),
        .cfg_rdata_out(rdata), .cfg_ack_out(ack), .mem_req_in(mem_req),
        .decode_valid_out(dv), .fwd_out(fwd), .prefetch_out(pf), .bridge_ctrl_out(brctl));
    initial forever #10 mclk_in = ~mclk_in;
    task automatic stop_test;
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Addresses stay dword aligned; the port ignores bits 1:0 anyway.
    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] d, input logic [31:0] exp);
        @(posedge mclk_in);
        cfg_req <= '{wr: w, rd: !w, addr: a, be: be, wdata: d};
        @(posedge mclk_in);
        cfg_req <= '0;
        #1;
        chk({31'h0, ack}, 32'h1);
        if (!w)
            chk(rdata, exp);
    endtask : cfg
    task automatic dec(input logic r, input logic [31:0] a, input logic [2:0] exp);
        @(posedge mclk_in);
        mem_req <= '{valid: 1'b1, read: r, addr: a};
        @(posedge mclk_in);
        mem_req <= '0;
        #1;
        chk({29'h0, dv, fwd, pf}, {29'h0, exp});
    endtask : dec
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_fields;
        cfg(0, BOUNDS_OFF, 4'hF, 0, BOUNDS_RST);
        dec(0, 32'h0010_0000, 3'b100);
        cfg(1, BOUNDS_OFF, 4'hF, 32'hFFFF_FFFF, 0);
        cfg(0, BOUNDS_OFF, 4'hF, 0, BOUNDS_WMASK);
        cfg(1, BOUNDS_OFF, 4'h2, 32'h0, 0);
        cfg(0, BOUNDS_OFF, 4'hF, 0, 32'hFFF0_00F0);
    endtask : t_fields
    task automatic t_window;
        cfg(1, BOUNDS_OFF, 4'hF, 32'h1250_1230, 0);
        dec(1, 32'h1230_0000, 3'b111);
        dec(1, 32'h122F_FFFF, 3'b100);
        dec(0, 32'h125F_FFFF, 3'b110);
        dec(1, 32'h1260_0000, 3'b100);
        cfg(1, BOUNDS_OFF, 4'hF, 32'h4560_4560, 0);
        dec(1, 32'h456A_BCDE, 3'b111);
        dec(1, 32'h4570_0000, 3'b100);
        cfg(1, BOUNDS_OFF, 4'hF, 32'h1000_2000, 0);
        dec(1, 32'h1500_0000, 3'b100);
        dec(1, 32'h2000_0000, 3'b100);
    endtask : t_window
    task automatic t_rsvd;
        // The sweep runs on past the span into bridge control and an unmapped dword.
        for (int a = 8'h28; a <= 8'h40; a += 4)
        begin
            cfg(1, 8'(a), 4'hF, 32'hFFFF_FFFF, 0);
            if (8'(a) == BRCTL_OFF)
                cfg(0, 8'(a), 4'hF, 0, {8'h00, BRCTL_WMASK, 16'h0000});
            else
                cfg(0, 8'(a), 4'hF, 0, READ_ZERO);
        end
        cfg(0, BOUNDS_OFF, 4'hF, 0, 32'h1000_2000);
        cfg(1, BRCTL_OFF, 4'hF, 32'hFFFF_FFFF, 0);
        cfg(0, BRCTL_OFF, 4'hF, 0, {8'h00, BRCTL_WMASK, 16'h0000});
        chk({24'h0, brctl}, {24'h0, BRCTL_WMASK});
    endtask : t_rsvd
    task automatic t_reset;
        cfg(1, BOUNDS_OFF, 4'hF, 32'h1250_1230, 0);
        cfg(1, BRCTL_OFF, 4'hF, 32'hFFFF_FFFF, 0);
        cfg(0, BOUNDS_OFF, 4'hF, 0, 32'h1250_1230);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        #1;
        chk(rdata, READ_ZERO);
        chk({24'h0, brctl}, {24'h0, BRCTL_RST});
        cfg(0, BOUNDS_OFF, 4'hF, 0, BOUNDS_RST);
        dec(1, 32'h1230_0000, 3'b100);
    endtask : t_reset
    initial
    begin
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_fields();
        t_window();
        t_rsvd();
        t_reset();
        stop_test();
    end
    always @(posedge mclk_in)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            stop_test();
        end
    end
endmodule : prefetch_window_config_regs_tb
bind prefetch_window_config_regs pfw_chk i_chk (.mclk_in(mclk_in), .rst_in(rst_in),
    .cfg_req_in(cfg_req_in), .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
    .mem_req_in(mem_req_in), .decode_valid_out(decode_valid_out), .fwd_out(fwd_out),
    .prefetch_out(prefetch_out), .bridge_ctrl_out(bridge_ctrl_out));
